/* verilog/cps_top.sv */
// Behaviour
// R1 - enable high, standby low, fault low-active input
// R2 - termination input level reported to software
// R3 - single-wire modes from standby and enable
// R4 - single-wire: fault input ignored for errors
// R5 - low-speed: standby and enable move together
// R6 - write sets outputs, read returns inputs
// R7 - traffic LED off until channel initialized
// R8 - each message starts 256 ms traffic blink; the code queues only one more blink for any messages during a running one
// R9 - power LED follows supply presence
// R10 - enumerating: state LED blink pattern one
// R11 - no host cable: blink pattern one too
// R12 - enumerated, not initialized: state LED on
// R13 - initialized, no error: state LED off
// R14 - bus error: blink pattern two
// R15 - firmware update: blink pattern three
// R16 - pattern one: 10 Hz, 1:1
// R17 - pattern three: 4 Hz, 4:1
// R18 - pattern two: fixed, distinct period
`timescale 1ns/100ps
`default_nettype none
`include "cps_defines.svh"

module cps_top #(
    parameter int TICK_DIV = `CPS_CLK_HZ / `CPS_MS_PER_S
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [`CPS_AW-1:0] ADDR,
    input wire logic [`CPS_DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [`CPS_DW-1:0] RDATA,
    // protocol controller events
    input wire logic CAN_TX_DONE,
    input wire logic CAN_RX_DONE,
    input wire logic CAN_BUS_ERR,
    // transceiver and board pins
    input wire logic FAULT_N,
    input wire logic TERMINATION_SENSE,
    input wire logic POWER_PRESENT,
    output logic XCVR_ENABLE,
    output logic XCVR_STANDBY_N,
    // indicators
    output logic TRAFFIC_LED,
    output logic STATE_LED,
    output logic POWER_LED
);
    localparam logic [9:0] TRAF_PER = 10'(`CPS_TRAFFIC_MS);
    localparam logic [9:0] TRAF_ON = 10'(`CPS_TRAFFIC_MS / 2);
    localparam logic [9:0] B1_PER = 10'(`CPS_MS_PER_S / `CPS_BLINK1_HZ);
    localparam logic [9:0] B1_ON = 10'(`CPS_MS_PER_S / `CPS_BLINK1_HZ / 2);
    localparam logic [9:0] B2_PER = 10'(`CPS_BLINK2_PERIOD_MS);
    localparam logic [9:0] B2_ON = 10'(`CPS_BLINK2_ON_MS);
    localparam logic [9:0] B3_PER = 10'(`CPS_MS_PER_S / `CPS_BLINK3_HZ);
    localparam logic [9:0] B3_ON =
        10'(`CPS_MS_PER_S / `CPS_BLINK3_HZ * `CPS_BLINK3_ON_PARTS / `CPS_BLINK3_ALL_PARTS);

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic fault_n_s;
    logic term_s;
    logic pwr_s;
    logic ms_tick;
    logic [1:0] ctrl_reg;
    cps_pkg::cps_kind_t kind_reg;
    logic init_reg;
    cps_pkg::cps_host_t host_reg;
    logic berr_reg;
    logic fault_seen;
    logic msg;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_host;
    logic wr_stat;
    logic t_active_reg;
    logic t_pend_reg;
    logic [9:0] t_cnt_reg;
    cps_pkg::cps_pat_t pat_next;
    cps_pkg::cps_pat_t pat_reg;
    logic [9:0] s_cnt_reg;
    logic [9:0] per;
    logic [9:0] on_ms;
    logic sled_next;
    logic [`CPS_DW-1:0] stat_val;

    // two-stage synchronisers for pin inputs; fault idles high
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg <= `CPS_SYNC_RST;
            sync2_reg <= `CPS_SYNC_RST;
        end else begin
            sync1_reg <= {POWER_PRESENT, TERMINATION_SENSE, FAULT_N};
            sync2_reg <= sync1_reg;
        end
    end
    assign fault_n_s = sync2_reg[0];
    assign term_s = sync2_reg[1];
    assign pwr_s = sync2_reg[2];

    cps_tick_div #(
        .DIV(TICK_DIV)
    ) u_ms (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(ms_tick)
    );

    assign wr_ctrl = WR && (ADDR == `CPS_ADDR_CTRL);
    assign wr_cfg = WR && (ADDR == `CPS_ADDR_CFG);
    assign wr_host = WR && (ADDR == `CPS_ADDR_HOST);
    assign wr_stat = WR && (ADDR == `CPS_ADDR_STAT);

    // transceiver control: both outputs reset high
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= `CPS_CTRL_RST; // [R1]
        end else if (wr_ctrl) begin
            if (kind_reg == cps_pkg::CPS_KIND_LS) begin
                ctrl_reg <= {2{WDATA[`CPS_CTRL_EN]}}; // [R5]
            end else begin
                ctrl_reg <= {WDATA[`CPS_CTRL_STBN], WDATA[`CPS_CTRL_EN]}; // [R6] [R3]
            end
        end
    end

    // low-speed part has the two pins tied, so the enable bit drives both
    assign XCVR_ENABLE = ctrl_reg[`CPS_CTRL_EN]; // [R1]
    assign XCVR_STANDBY_N = (kind_reg == cps_pkg::CPS_KIND_LS) ?
        ctrl_reg[`CPS_CTRL_EN] : ctrl_reg[`CPS_CTRL_STBN]; // [R5] [R3]

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            kind_reg <= cps_pkg::CPS_KIND_HS;
            init_reg <= 1'b0;
        end else if (wr_cfg) begin
            // code 2'b11 is not a fitted transceiver: keep the old one
            if (WDATA[`CPS_CFG_KIND_HI:`CPS_CFG_KIND_LO] != `CPS_CODE_UNUSED) begin
                kind_reg <= cps_pkg::cps_kind_t'(WDATA[`CPS_CFG_KIND_HI:`CPS_CFG_KIND_LO]);
            end
            init_reg <= WDATA[`CPS_CFG_INIT];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            host_reg <= cps_pkg::CPS_HOST_LOGIN;
        end else if (wr_host && WDATA[`CPS_HOST_HI:`CPS_HOST_LO] != `CPS_CODE_UNUSED) begin
            host_reg <= cps_pkg::cps_host_t'(WDATA[`CPS_HOST_HI:`CPS_HOST_LO]);
        end
    end

    // single-wire part has no fault pin; its line floats and means nothing
    assign fault_seen = !fault_n_s && (kind_reg != cps_pkg::CPS_KIND_SW); // [R4]

    // sticky bus error, write one to clear; a new error wins over the clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            berr_reg <= 1'b0;
        end else if (CAN_BUS_ERR || fault_seen) begin
            berr_reg <= 1'b1; // [R1] [R14]
        end else if (wr_stat && WDATA[`CPS_STAT_BERR]) begin
            berr_reg <= 1'b0;
        end
    end

    // traffic blink; messages inside a running cycle queue one more cycle
    assign msg = (CAN_TX_DONE || CAN_RX_DONE) && init_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            t_active_reg <= 1'b0;
            t_pend_reg <= 1'b0;
            t_cnt_reg <= '0;
        end else if (!init_reg) begin
            t_active_reg <= 1'b0; // [R7]
            t_pend_reg <= 1'b0;
            t_cnt_reg <= '0;
        end else if (!t_active_reg) begin
            t_active_reg <= msg; // [R8]
            t_cnt_reg <= '0;
        end else if (ms_tick && t_cnt_reg == TRAF_PER - 10'h001) begin
            t_active_reg <= t_pend_reg || msg; // [R8]
            t_pend_reg <= 1'b0;
            t_cnt_reg <= '0;
        end else begin
            t_pend_reg <= t_pend_reg || msg;
            if (ms_tick) begin
                t_cnt_reg <= t_cnt_reg + 10'h001;
            end
        end
    end

    // state pattern, highest priority first
    always_comb begin
        if (host_reg == cps_pkg::CPS_HOST_FWUPD) begin
            pat_next = cps_pkg::CPS_LED_BLINK3; // [R15]
        end else if (berr_reg) begin
            pat_next = cps_pkg::CPS_LED_BLINK2; // [R14]
        end else if (host_reg == cps_pkg::CPS_HOST_LOGIN) begin
            pat_next = cps_pkg::CPS_LED_BLINK1; // [R10] [R11]
        end else if (!init_reg) begin
            pat_next = cps_pkg::CPS_LED_ON; // [R12]
        end else begin
            pat_next = cps_pkg::CPS_LED_OFF; // [R13]
        end
    end

    always_comb begin
        unique case (pat_reg)
            cps_pkg::CPS_LED_BLINK1: begin
                per = B1_PER; // [R16]
                on_ms = B1_ON;
            end
            cps_pkg::CPS_LED_BLINK2: begin
                per = B2_PER; // [R18]
                on_ms = B2_ON;
            end
            cps_pkg::CPS_LED_BLINK3: begin
                per = B3_PER; // [R17]
                on_ms = B3_ON;
            end
            cps_pkg::CPS_LED_ON: begin
                per = B1_PER;
                on_ms = B1_PER;
            end
            cps_pkg::CPS_LED_OFF: begin
                per = B1_PER;
                on_ms = 10'h000;
            end
            default: begin
                per = B1_PER;
                on_ms = 10'h000;
            end
        endcase
    end

    // phase restarts on a change so each pattern opens with its on time
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pat_reg <= cps_pkg::CPS_LED_BLINK1;
            s_cnt_reg <= '0;
        end else if (pat_next != pat_reg) begin
            pat_reg <= pat_next;
            s_cnt_reg <= '0;
        end else if (ms_tick) begin
            s_cnt_reg <= (s_cnt_reg == per - 10'h001) ? 10'h000 : s_cnt_reg + 10'h001;
        end
    end

    assign sled_next = (pat_reg == pat_next) && (s_cnt_reg < on_ms);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            STATE_LED <= 1'b0;
            TRAFFIC_LED <= 1'b0;
            POWER_LED <= 1'b0;
        end else begin
            STATE_LED <= sled_next;
            TRAFFIC_LED <= t_active_reg && init_reg && (t_cnt_reg < TRAF_ON); // [R7] [R8]
            POWER_LED <= pwr_s; // [R9]
        end
    end

    always_comb begin
        stat_val = '0;
        stat_val[`CPS_STAT_FAULT] = fault_n_s || (kind_reg == cps_pkg::CPS_KIND_SW); // [R4]
        stat_val[`CPS_STAT_TERM] = term_s; // [R2]
        stat_val[`CPS_STAT_BERR] = berr_reg;
        stat_val[`CPS_STAT_TLED] = TRAFFIC_LED;
        stat_val[`CPS_STAT_SLED] = STATE_LED;
        stat_val[`CPS_STAT_PLED] = POWER_LED;
    end

    // read data stands for one cycle only; unmapped reads return zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= `CPS_RDATA_RST;
        end else if (RD) begin
            unique case (ADDR)
                `CPS_ADDR_CTRL: RDATA <= {6'h00, XCVR_STANDBY_N, XCVR_ENABLE};
                `CPS_ADDR_CFG: RDATA <= {5'h00, init_reg, kind_reg};
                `CPS_ADDR_HOST: RDATA <= {6'h00, host_reg};
                `CPS_ADDR_STAT: RDATA <= stat_val; // [R6]
                default: RDATA <= `CPS_RDATA_RST;
            endcase
        end else begin
            RDATA <= `CPS_RDATA_RST;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_ctrl_write_out: assert property ( // [R6] [R3]
        wr_ctrl && kind_reg != cps_pkg::CPS_KIND_LS && !wr_cfg
        |=> XCVR_ENABLE == $past(WDATA[`CPS_CTRL_EN]) && XCVR_STANDBY_N == $past(WDATA[`CPS_CTRL_STBN]))
        else $error("transceiver outputs did not follow the write");
    a_ls_tied_pair: assert property ( // [R5]
        kind_reg == cps_pkg::CPS_KIND_LS && wr_ctrl
        |=> XCVR_ENABLE == $past(WDATA[`CPS_CTRL_EN]) && XCVR_STANDBY_N == $past(WDATA[`CPS_CTRL_EN]))
        else $error("low-speed standby and enable differ");
    a_term_read_back: assert property ( // [R2]
        RD && ADDR == `CPS_ADDR_STAT |=> RDATA[`CPS_STAT_TERM] == $past(term_s))
        else $error("termination level not returned");
    a_fault_sets_err: assert property ( // [R1]
        !fault_n_s && kind_reg != cps_pkg::CPS_KIND_SW |=> berr_reg)
        else $error("fault input did not raise bus error");
    a_sw_fault_ignored: assert property ( // [R4]
        kind_reg == cps_pkg::CPS_KIND_SW && !CAN_BUS_ERR && !berr_reg && !wr_cfg |=> !berr_reg)
        else $error("single-wire fault input raised an error");
    a_traffic_dark: assert property ( // [R7]
        !init_reg |=> !TRAFFIC_LED)
        else $error("traffic LED lit before initialization");
    a_traffic_start: assert property ( // [R8]
        msg && !t_active_reg && !wr_cfg |=> ##1 TRAFFIC_LED)
        else $error("message did not start traffic blink");
    a_power_follow: assert property ( // [R9]
        pwr_s != POWER_LED |=> POWER_LED != $past(POWER_LED))
        else $error("power LED not on with supply");
    a_login_blink: assert property ( // [R10] [R11]
        host_reg == cps_pkg::CPS_HOST_LOGIN && !berr_reg |-> pat_next == cps_pkg::CPS_LED_BLINK1)
        else $error("login state not blink pattern one");
    a_state_solid_on: assert property ( // [R12]
        pat_reg == cps_pkg::CPS_LED_ON && pat_next == cps_pkg::CPS_LED_ON |=> STATE_LED)
        else $error("state LED not lit while uninitialized");
    a_state_dark: assert property ( // [R13]
        pat_reg == cps_pkg::CPS_LED_OFF |=> !STATE_LED)
        else $error("state LED lit after initialization");
    a_err_pattern: assert property ( // [R14]
        berr_reg && host_reg != cps_pkg::CPS_HOST_FWUPD |-> pat_next == cps_pkg::CPS_LED_BLINK2)
        else $error("bus error not shown as pattern two");
    a_fw_pattern: assert property ( // [R15]
        host_reg == cps_pkg::CPS_HOST_FWUPD |-> pat_next == cps_pkg::CPS_LED_BLINK3)
        else $error("firmware update not shown as pattern three");
    a_blink1_phase: assert property ( // [R16]
        pat_reg == cps_pkg::CPS_LED_BLINK1 && pat_next == pat_reg
        |=> STATE_LED == ($past(s_cnt_reg) < B1_ON))
        else $error("pattern one duty wrong");
    a_blink2_phase: assert property ( // [R18]
        pat_reg == cps_pkg::CPS_LED_BLINK2 && pat_next == pat_reg
        |=> STATE_LED == ($past(s_cnt_reg) < B2_ON))
        else $error("pattern two duty wrong");
    a_blink3_phase: assert property ( // [R17]
        pat_reg == cps_pkg::CPS_LED_BLINK3 && pat_next == pat_reg
        |=> STATE_LED == ($past(s_cnt_reg) < B3_ON))
        else $error("pattern three duty wrong");

    c_sw_fast_mode: cover property (
        kind_reg == cps_pkg::CPS_KIND_SW && {XCVR_STANDBY_N, XCVR_ENABLE} == cps_pkg::CPS_SW_FAST);
    c_traffic_requeue: cover property (t_pend_reg && t_active_reg);
    c_err_cleared: cover property (berr_reg ##1 !berr_reg);
    c_fw_update: cover property (pat_reg == cps_pkg::CPS_LED_BLINK3 && STATE_LED);
endmodule

`default_nettype wire

/* verilog/cps_defines.svh */
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

// register offsets
`define CPS_AW 4
`define CPS_DW 8
`define CPS_ADDR_CTRL 4'h0
`define CPS_ADDR_CFG 4'h4
`define CPS_ADDR_HOST 4'h8
`define CPS_ADDR_STAT 4'hC

// field positions
`define CPS_CTRL_EN 0
`define CPS_CTRL_STBN 1
`define CPS_CFG_KIND_LO 0
`define CPS_CFG_KIND_HI 1
`define CPS_CFG_INIT 2
`define CPS_HOST_LO 0
`define CPS_HOST_HI 1
`define CPS_STAT_FAULT 0
`define CPS_STAT_TERM 1
`define CPS_STAT_BERR 2
`define CPS_STAT_TLED 3
`define CPS_STAT_SLED 4
`define CPS_STAT_PLED 5

// reset values and the refused field code
`define CPS_CTRL_RST 2'h3
`define CPS_RDATA_RST 8'h00
`define CPS_SYNC_RST 3'h1
`define CPS_CODE_UNUSED 2'h3

// timing
`define CPS_CLK_HZ 100000000
`define CPS_MS_PER_S 1000
`define CPS_TRAFFIC_MS 256
`define CPS_BLINK1_HZ 10
`define CPS_BLINK3_HZ 4
`define CPS_BLINK3_ON_PARTS 4
`define CPS_BLINK3_ALL_PARTS 5
`define CPS_BLINK2_PERIOD_MS 1000
`define CPS_BLINK2_ON_MS 200

`endif

/* verilog/cps_pkg.sv */
`default_nettype none

package cps_pkg;

    typedef enum logic [1:0] {
        CPS_KIND_HS = 2'b00,
        CPS_KIND_LS = 2'b01,
        CPS_KIND_SW = 2'b10
    } cps_kind_t;

    typedef enum logic [1:0] {
        CPS_HOST_LOGIN = 2'b00,
        CPS_HOST_READY = 2'b01,
        CPS_HOST_FWUPD = 2'b10
    } cps_host_t;

    typedef enum logic [2:0] {
        CPS_LED_OFF = 3'b000,
        CPS_LED_ON = 3'b001,
        CPS_LED_BLINK1 = 3'b010,
        CPS_LED_BLINK2 = 3'b011,
        CPS_LED_BLINK3 = 3'b100
    } cps_pat_t;

    // {standby_n, enable} of the single-wire transceiver
    typedef enum logic [1:0] {
        CPS_SW_SLEEP = 2'b00,
        CPS_SW_WAKE = 2'b01,
        CPS_SW_FAST = 2'b10,
        CPS_SW_NORMAL = 2'b11
    } cps_sw_mode_t;

endpackage

`default_nettype wire

/* verilog/cps_tick_div.sv */
`timescale 1ns/100ps
`default_nettype none

module cps_tick_div #(
    parameter int DIV = 100000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // one-cycle pulse every DIV cycles
    output logic tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (cnt_reg == W'(DIV - 1)) begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
            tick <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* test/cps_xcvr_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cps_xcvr_model (
    // control from the device
    input wire logic enable,
    input wire logic standby_n,
    // bench controls
    input wire logic fault_req,
    input wire logic term_fitted,
    // pins back to the device, and the single-wire mode for the bench
    output logic fault_n,
    output logic termination_sense,
    output var cps_pkg::cps_sw_mode_t sw_mode
);
    // pull-up holds the line high; a floating pin on the single-wire part may still read low
    assign fault_n = !fault_req;
    // open jumper reads low
    assign termination_sense = term_fitted;
    assign sw_mode = cps_pkg::cps_sw_mode_t'({standby_n, enable});
endmodule

`default_nettype wire

/* test/test_can_port_status_control.sv */
`timescale 1ns/100ps
`default_nettype none

module test_can_port_status_control;
    localparam int TD = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] msg_v = 2'b00;
    logic bus_err = 1'b0;
    logic power_present = 1'b0;
    logic fault_req = 1'b0;
    logic term_fitted = 1'b0;
    logic [7:0] rdata;
    logic fault_n, term_sense, xen, xstb_n, tled, sled, pled;
    cps_pkg::cps_sw_mode_t sw_mode;
    int mismatches = 0;
    int checks_done = 0;
    int ones;

    always #5 clk = ~clk;

    cps_top #(.TICK_DIV(TD)) dut (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CAN_TX_DONE(msg_v[0]), .CAN_RX_DONE(msg_v[1]), .CAN_BUS_ERR(bus_err),
        .FAULT_N(fault_n), .TERMINATION_SENSE(term_sense), .POWER_PRESENT(power_present),
        .XCVR_ENABLE(xen), .XCVR_STANDBY_N(xstb_n),
        .TRAFFIC_LED(tled), .STATE_LED(sled), .POWER_LED(pled)
    );

    cps_xcvr_model xcvr (
        .enable(xen), .standby_n(xstb_n), .fault_req(fault_req), .term_fitted(term_fitted),
        .fault_n(fault_n), .termination_sense(term_sense), .sw_mode(sw_mode)
    );

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(rdata & m, exp);
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        msg_v[k] <= 1'b1;
        @(posedge clk);
        msg_v[k] <= 1'b0;
    endtask

    // pins change at an edge; settle time covers the two-stage input synchronisers
    task automatic pins(input logic f, input logic t);
        @(posedge clk);
        fault_req <= f;
        term_fitted <= t;
        repeat (4) @(posedge clk);
    endtask

    task automatic count_on(input int n);
        ones = 0;
        repeat (n) begin
            @(posedge clk);
            #1 if (sled === 1'b1) ones++;
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("MISMATCH %0t run did not finish", $time);
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        #1 chk8({5'h00, pled, xstb_n, xen}, 8'h03);
        @(posedge clk);
        rst_n <= 1'b1;
        power_present <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk8({7'h00, pled}, 8'h01);
        chk_rd(4'h0, 8'hFF, 8'h03);
        wr_reg(4'h4, 8'h02);
        for (int m = 0; m < 4; m++) begin
            wr_reg(4'h0, m[7:0]);
            #1 chk8({6'h00, sw_mode}, m[7:0]);
        end
        pins(1'b1, 1'b0);
        chk_rd(4'hC, 8'h07, 8'h01);
        pins(1'b0, 1'b0);
        wr_reg(4'h4, 8'h01);
        wr_reg(4'h0, 8'h01);
        #1 chk8({6'h00, xstb_n, xen}, 8'h03);
        wr_reg(4'h0, 8'h02);
        #1 chk8({6'h00, xstb_n, xen}, 8'h00);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h0, 8'h02);
        #1 chk8({6'h00, xstb_n, xen}, 8'h02);
        pins(1'b0, 1'b1);
        chk_rd(4'hC, 8'h07, 8'h03);
        pins(1'b1, 1'b0);
        chk_rd(4'hC, 8'h07, 8'h04);
        pins(1'b0, 1'b0);
        wr_reg(4'hC, 8'h04);
        chk_rd(4'hC, 8'h07, 8'h01);
        // traffic events before init must stay dark
        pulse(1);
        repeat (5) @(posedge clk);
        #1 chk8({7'h00, tled}, 8'h00);
        wr_reg(4'h4, 8'h04);
        for (int k = 0; k < 2; k++) begin
            pulse(k);
            repeat (2) @(posedge clk);
            #1 chk8({7'h00, tled}, 8'h01);
            repeat (1200) @(posedge clk);
            #1 chk8({7'h00, tled}, 8'h01);
            repeat (200) @(posedge clk);
            #1 chk8({7'h00, tled}, 8'h00);
            repeat (1300) @(posedge clk);
        end
        // a message in the dark half queues exactly one more cycle
        pulse(0);
        repeat (1500) @(posedge clk);
        pulse(1);
        repeat (1200) @(posedge clk);
        #1 chk8({7'h00, tled}, 8'h01);
        repeat (1300) @(posedge clk);
        #1 chk8({7'h00, tled}, 8'h00);
        // refused codes keep the old value, unmapped reads give zero
        wr_reg(4'h4, 8'h07);
        chk_rd(4'h4, 8'hFF, 8'h04);
        wr_reg(4'h8, 8'h03);
        chk_rd(4'h8, 8'hFF, 8'h00);
        chk_rd(4'h2, 8'hFF, 8'h00);
        // whole periods so the start phase does not matter
        count_on(20 * TD * 10);
        chk_cnt(ones, 980, 1020);
        wr_reg(4'h8, 8'h01);
        wr_reg(4'h4, 8'h00);
        repeat (3) @(posedge clk);
        count_on(100);
        chk_cnt(ones, 100, 100);
        wr_reg(4'h4, 8'h04);
        repeat (3) @(posedge clk);
        count_on(100);
        chk_cnt(ones, 0, 0);
        @(posedge clk);
        bus_err <= 1'b1;
        @(posedge clk);
        bus_err <= 1'b0;
        count_on(10000);
        chk_cnt(ones, 1980, 2020);
        wr_reg(4'h8, 8'h02);
        count_on(2500);
        chk_cnt(ones, 1980, 2020);
        wr_reg(4'hC, 8'h04);
        wr_reg(4'h8, 8'h01);
        repeat (3) @(posedge clk);
        count_on(50);
        chk_cnt(ones, 0, 0);
        @(posedge clk);
        power_present <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk8({7'h00, pled}, 8'h00);
        results();
    end
endmodule

`default_nettype wire
